// File: hw/fepcs_line_coding.sv
// 100 Mb/s transmit and receive line coding: 4B/5B, scrambling, NRZI, MLT-3
`timescale 1ns/1ps
`default_nettype none
`include "fepcs_consts.svh"

module fepcs_line_coding
	import fepcs_pkg::*;
#(
	parameter int BIT_DIV = 1,
	parameter int HOLD_CYCLES = `FEPCS_HOLD_CYC,
	parameter int HOLD_W = 16
)(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [4:0] phy_address_straps,
	input wire logic txEn,
	input wire logic [3:0] txd,
	input wire logic [4:0] txSymIn,
	input wire logic encBypass,
	input wire logic scrBypass,
	output logic txNibbleTake,
	output logic txPos,
	output logic txNeg,
	input wire logic rxPosPin,
	input wire logic rxNegPin,
	input wire logic energyPin,
	input wire logic linkPulsePin,
	output logic sigDetect,
	output logic rxLocked,
	output logic [4:0] rxSym,
	output logic rxSymValid
);
	localparam int LOCK_BITS = `FEPCS_LOCK_BITS;
	localparam int IDLE_BITS = `FEPCS_IDLE_BITS;

	// Bit-rate enable
	logic [7:0] divCnt_r;
	wire bitEn = (divCnt_r == 8'h00);
	always_ff @(posedge mclk)
		if (!rstn || divCnt_r == 8'(BIT_DIV - 1))
			divCnt_r <= 8'h00;
		else
			divCnt_r <= divCnt_r + 8'h01;

	// Pin synchronisers
	logic [4:0] strapMeta_r, strapSync_r;
	logic [3:0] pinMeta_r, pinSync_r;
	always_ff @(posedge mclk)
	begin
		strapMeta_r <= phy_address_straps;
		strapSync_r <= strapMeta_r;
		pinMeta_r <= {rxPosPin, rxNegPin, energyPin, linkPulsePin};
		pinSync_r <= pinMeta_r;
	end
	wire rxPosS = pinSync_r[3];
	wire rxNegS = pinSync_r[2];
	wire energyS = pinSync_r[1];
	wire pulseS = pinSync_r[0];

	// Seed load once the strap synchroniser has settled
	logic [1:0] initCnt_r;
	wire seedLoad = (initCnt_r == 2'h2);
	wire txRun = (initCnt_r == 2'h3);
	always_ff @(posedge mclk)
		if (!rstn)
			initCnt_r <= 2'h0;
		else if (!txRun)
			initCnt_r <= initCnt_r + 2'h1;

	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		case (n)
			4'h0: enc4b5b = 5'h1E;
			4'h1: enc4b5b = 5'h09;
			4'h2: enc4b5b = 5'h14;
			4'h3: enc4b5b = 5'h15;
			4'h4: enc4b5b = 5'h0A;
			4'h5: enc4b5b = 5'h0B;
			4'h6: enc4b5b = 5'h0E;
			4'h7: enc4b5b = 5'h0F;
			4'h8: enc4b5b = 5'h12;
			4'h9: enc4b5b = 5'h13;
			4'hA: enc4b5b = 5'h16;
			4'hB: enc4b5b = 5'h17;
			4'hC: enc4b5b = 5'h1A;
			4'hD: enc4b5b = 5'h1B;
			4'hE: enc4b5b = 5'h1C;
			default: enc4b5b = 5'h1D;
		endcase
	endfunction

	// Transmit code-group sequencing
	fepcs_tx_st_t txSt_r, txSt_nxt;
	logic [2:0] txBitCnt_r;
	logic [4:0] txShift_r;
	wire txBound = txRun && bitEn && (txBitCnt_r == 3'h4);
	always_comb
	begin
		txSt_nxt = txSt_r;
		unique case (txSt_r)
			FEPCS_TX_IDLE: if (txEn) txSt_nxt = FEPCS_TX_J;
			FEPCS_TX_J: txSt_nxt = FEPCS_TX_K;
			FEPCS_TX_K: txSt_nxt = txEn ? FEPCS_TX_DATA : FEPCS_TX_T;
			FEPCS_TX_DATA: if (!txEn) txSt_nxt = FEPCS_TX_T;
			FEPCS_TX_T: txSt_nxt = FEPCS_TX_R;
			FEPCS_TX_R: txSt_nxt = FEPCS_TX_IDLE;
			default: txSt_nxt = FEPCS_TX_IDLE;
		endcase
	end
	wire [4:0] dataCode = encBypass ? txSymIn : enc4b5b(txd);
	wire [4:0] codeNxt =
		(txSt_nxt == FEPCS_TX_J) ? `FEPCS_CODE_J :
		(txSt_nxt == FEPCS_TX_K) ? `FEPCS_CODE_K :
		(txSt_nxt == FEPCS_TX_DATA) ? dataCode :
		(txSt_nxt == FEPCS_TX_T) ? `FEPCS_CODE_T :
		(txSt_nxt == FEPCS_TX_R) ? `FEPCS_CODE_R : `FEPCS_CODE_I;
	wire takeNibble = txBound && txEn && (txSt_nxt != FEPCS_TX_T);
	always_ff @(posedge mclk)
		if (!rstn)
		begin
			txSt_r <= FEPCS_TX_IDLE;
			txBitCnt_r <= 3'h0;
			txShift_r <= `FEPCS_CODE_I;
			txNibbleTake <= 1'b0;
		end
		else
		begin
			txNibbleTake <= takeNibble;
			if (txBound)
			begin
				txSt_r <= txSt_nxt;
				txBitCnt_r <= 3'h0;
				txShift_r <= codeNxt;
			end
			else if (txRun && bitEn)
			begin
				txBitCnt_r <= txBitCnt_r + 3'h1;
				txShift_r <= {txShift_r[3:0], 1'b0};
			end
		end

	// Scrambler, NRZI and MLT-3 split
	logic [10:0] txLfsr_r;
	logic txNrzi_r;
	logic [1:0] mltPh_r;
	wire txKey = txLfsr_r[`FEPCS_TAP_HI] ^ txLfsr_r[`FEPCS_TAP_LO];
	wire scrBit = txShift_r[4] ^ (txKey & ~scrBypass);
	wire txStep = txRun && bitEn;
	wire txNrziNxt = txNrzi_r ^ scrBit;
	wire [1:0] mltPhNxt = mltPh_r + {1'b0, txNrziNxt ^ txNrzi_r};
	always_ff @(posedge mclk)
		if (!rstn)
		begin
			txLfsr_r <= 11'h000;
			txNrzi_r <= 1'b0;
			mltPh_r <= 2'h0;
			txPos <= 1'b0;
			txNeg <= 1'b0;
		end
		else if (seedLoad)
			txLfsr_r <= {strapSync_r[4:1], `FEPCS_SEED_LOW};
		else if (txStep)
		begin
			txLfsr_r <= {txLfsr_r[9:0], txKey};
			txNrzi_r <= txNrziNxt;
			mltPh_r <= mltPhNxt;
			txPos <= (mltPhNxt == 2'h1);
			txNeg <= (mltPhNxt == 2'h3);
		end

	// Receive MLT-3 to NRZI to NRZ
	logic [1:0] rxLvlPrev_r;
	logic rxNrzi_r, rxNrziPrev_r, rxBitVld_r;
	wire rxChange = ({rxPosS, rxNegS} != rxLvlPrev_r);
	always_ff @(posedge mclk)
		if (!rstn)
		begin
			rxLvlPrev_r <= 2'h0;
			rxNrzi_r <= 1'b0;
			rxNrziPrev_r <= 1'b0;
			rxBitVld_r <= 1'b0;
			sigDetect <= 1'b0;
		end
		else
		begin
			sigDetect <= energyS & ~pulseS;
			rxBitVld_r <= bitEn;
			if (bitEn)
			begin
				rxLvlPrev_r <= {rxPosS, rxNegS};
				rxNrzi_r <= rxNrzi_r ^ rxChange;
				rxNrziPrev_r <= rxNrzi_r;
			end
		end
	wire rxNrz = rxNrzi_r ^ rxNrziPrev_r;

	// Descrambler with lock and hold timer
	fepcs_rx_st_t rxSt_r;
	logic [10:0] rxLfsr_r;
	logic [5:0] onesCnt_r;
	logic [HOLD_W-1:0] holdCnt_r;
	logic [2:0] rxBitCnt_r;
	logic [4:0] rxShift_r;
	wire rxKey = rxLfsr_r[`FEPCS_TAP_HI] ^ rxLfsr_r[`FEPCS_TAP_LO];
	wire udBit = rxNrz ^ rxKey;
	wire lockHit = (rxSt_r == FEPCS_RX_HUNT) && rxBitVld_r && udBit
		&& (onesCnt_r == 6'(LOCK_BITS - 1));
	wire idleHit = (rxSt_r == FEPCS_RX_LOCK) && rxBitVld_r && udBit
		&& (onesCnt_r == 6'(IDLE_BITS - 1));
	wire holdOut = (rxSt_r == FEPCS_RX_LOCK) && (holdCnt_r == '0);
	wire [4:0] rxShiftNxt = {rxShift_r[3:0], udBit};
	always_ff @(posedge mclk)
		if (!rstn || holdOut)
		begin
			rxSt_r <= FEPCS_RX_HUNT;
			rxLfsr_r <= 11'h000;
			onesCnt_r <= 6'h00;
			holdCnt_r <= '0;
			rxBitCnt_r <= 3'h0;
			rxShift_r <= 5'h00;
			rxSym <= 5'h00;
			rxSymValid <= 1'b0;
			rxLocked <= 1'b0;
		end
		else
		begin
			rxSymValid <= 1'b0;
			if (rxSt_r == FEPCS_RX_LOCK)
				holdCnt_r <= idleHit ? HOLD_W'(HOLD_CYCLES - 1) : holdCnt_r - 1'b1;
			if (rxBitVld_r)
			begin
				if (rxSt_r == FEPCS_RX_HUNT)
					rxLfsr_r <= {rxLfsr_r[9:0], ~rxNrz};
				else
					rxLfsr_r <= {rxLfsr_r[9:0], rxKey};
				onesCnt_r <= (!udBit || lockHit || idleHit) ? 6'h00 : onesCnt_r + 6'h01;
				rxShift_r <= rxShiftNxt;
				rxBitCnt_r <= (rxBitCnt_r == 3'h4) ? 3'h0 : rxBitCnt_r + 3'h1;
				if (rxBitCnt_r == 3'h4 && rxSt_r == FEPCS_RX_LOCK)
				begin
					rxSym <= rxShiftNxt;
					rxSymValid <= 1'b1;
				end
			end
			if (lockHit)
			begin
				rxSt_r <= FEPCS_RX_LOCK;
				rxLocked <= 1'b1;
				holdCnt_r <= HOLD_W'(HOLD_CYCLES - 1);
			end
		end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	jk_start_a: assert property (txBound && txSt_r == FEPCS_TX_IDLE && txEn
		|=> txSt_r == FEPCS_TX_J && txShift_r == `FEPCS_CODE_J)
		else $error("start delimiter J not sent");
	tr_end_a: assert property (txBound && txSt_r == FEPCS_TX_DATA && !txEn
		|=> txSt_r == FEPCS_TX_T ##1 (txSt_r == FEPCS_TX_T) [*4] ##1 txSt_r == FEPCS_TX_R)
		else $error("end delimiter T then R not sent");
	idle_fill_a: assert property (txBound && txSt_r == FEPCS_TX_R
		|=> txSt_r == FEPCS_TX_IDLE && txShift_r == `FEPCS_CODE_I)
		else $error("idle not sent after end delimiter");
	data_code_a: assert property (txBound && txSt_nxt == FEPCS_TX_DATA && !encBypass
		|=> txShift_r == enc4b5b($past(txd)))
		else $error("data nibble not encoded");
	nrzi_tx_a: assert property (txStep |=> txNrzi_r == ($past(txNrzi_r) ^ $past(scrBit)))
		else $error("nrzi did not follow scrambled bit");
	mlt_split_a: assert property (!$rose(txPos) || $past(mltPh_r) == 2'h0)
		else $error("mlt-3 streams out of phase");
	mlt_excl_a: assert property (!(txPos && txNeg))
		else $error("mlt-3 streams overlap");
	lfsr_live_a: assert property (txRun |-> txLfsr_r != 11'h000)
		else $error("scrambler lfsr stuck at zero");
	sd_pulse_a: assert property (pulseS |=> !sigDetect)
		else $error("signal detect raised on link pulses");
	lock_cnt_a: assert property ($rose(rxLocked) |-> $past(onesCnt_r) == 6'(LOCK_BITS - 1))
		else $error("lock declared without twelve idle groups");
	hold_start_a: assert property ($rose(rxLocked) |-> holdCnt_r == HOLD_W'(HOLD_CYCLES - 1))
		else $error("hold timer not started on lock");
	hold_drop_a: assert property (holdOut |=> !rxLocked && rxSt_r == FEPCS_RX_HUNT)
		else $error("lock kept after hold expiry");
	sym_gate_a: assert property (rxSymValid |-> rxLocked)
		else $error("symbol output while unlocked");

	k_follow_a: assert property (txBound && txSt_r == FEPCS_TX_J
		|=> txSt_r == FEPCS_TX_K && txShift_r == `FEPCS_CODE_K)
		else $error("start delimiter K not sent");
	enc_bypass_a: assert property (txBound && txSt_nxt == FEPCS_TX_DATA && encBypass
		|=> txShift_r == $past(txSymIn))
		else $error("bypassed code-group not sent");
	take_pulse_a: assert property (txNibbleTake
		|=> !txNibbleTake)
		else $error("nibble take longer than one cycle");
	seed_load_a: assert property (seedLoad
		|=> txLfsr_r == {$past(strapSync_r[4:1]), `FEPCS_SEED_LOW})
		else $error("scrambler seed not taken from straps");
	lfsr_shift_a: assert property (txStep
		|=> txLfsr_r == {$past(txLfsr_r[9:0]), $past(txLfsr_r[10] ^ txLfsr_r[8])})
		else $error("scrambler lfsr did not step");
	scr_xor_a: assert property (txStep && !scrBypass
		|=> txNrzi_r == ($past(txNrzi_r) ^ $past(txShift_r[4]) ^ $past(txKey)))
		else $error("transmit bit not scrambled");
	scr_bypass_a: assert property (txStep && scrBypass
		|=> txNrzi_r == ($past(txNrzi_r) ^ $past(txShift_r[4])))
		else $error("bypassed bit was scrambled");
	mlt_step_a: assert property (txStep
		|=> mltPh_r == $past(mltPh_r) + {1'b0, txNrzi_r ^ $past(txNrzi_r)})
		else $error("mlt-3 phase did not follow nrzi");

	sd_energy_a: assert property (energyS && !pulseS
		|=> sigDetect)
		else $error("signal detect missing with energy");
	rx_nrzi_a: assert property (bitEn
		|=> rxNrzi_r == ($past(rxNrzi_r) ^ $past(rxChange)))
		else $error("receive nrzi did not follow line change");
	hunt_load_a: assert property (rxBitVld_r && rxSt_r == FEPCS_RX_HUNT
		|=> rxLfsr_r[0] == !$past(rxNrz))
		else $error("hunt did not load inverted bit");
	rx_lock_up_a: assert property (lockHit
		|=> rxLocked && rxSt_r == FEPCS_RX_LOCK)
		else $error("lock not declared after idle run");
	desc_run_a: assert property (rxBitVld_r && rxSt_r == FEPCS_RX_LOCK && !holdOut
		|=> rxLfsr_r == {$past(rxLfsr_r[9:0]), $past(rxKey)})
		else $error("descrambler did not free run");
	hold_refresh_a: assert property (idleHit && !holdOut
		|=> holdCnt_r == HOLD_W'(HOLD_CYCLES - 1))
		else $error("hold timer not restarted on idle");
	hold_count_a: assert property (rxSt_r == FEPCS_RX_LOCK && !idleHit && !holdOut
		|=> holdCnt_r == $past(holdCnt_r) - HOLD_W'(1))
		else $error("hold timer did not count down");
	sym_cadence_a: assert property (rxSymValid
		|=> !rxSymValid [*4])
		else $error("symbol strobe faster than five bits");

	pkt_c: cover property (txBound && txSt_r == FEPCS_TX_R);
	lock_c: cover property ($rose(rxLocked));
	refresh_c: cover property (idleHit);
	drop_c: cover property (holdOut);
	bypass_c: cover property (txBound && encBypass && txSt_nxt == FEPCS_TX_DATA);
endmodule
`default_nettype wire

// File: hw/fepcs_consts.svh
// Constants for the 100 Mb/s line coding block
// Summary of operation
// - Encode each transmit nibble into five-bit code-group
// - Send J then K for first preamble byte
// - Append T then R when enable drops
// - Send IDLE continuously until enable returns
// - Scrambler is an eleven-bit closed-loop LFSR
// - XOR each serial bit with LFSR key
// - Seed scrambler from upper four address straps
// - NRZI encode the scrambled stream before driving
// - Split NRZI into alternating positive/negative streams
// - Transmit output is MLT-3 only, no binary
// - Signal detect stays low on link pulses
// - Turn received MLT-3 back into NRZI
// - Decode received NRZI to NRZ before descrambling
// - Deserialise received bits into five-bit symbols
// - Descramble with identical key sequence XOR
// - Lock after twelve all-ones IDLE code-groups
// - Start 722 us hold timer on lock
// - Restart hold timer after 58 idle bits
// - Drop lock and reset on hold expiry
// - Use published 4B/5B code table
// - Offer scrambler and encoder bypass
`ifndef FEPCS_CONSTS_SVH
`define FEPCS_CONSTS_SVH

`define FEPCS_SYM_W 5
`define FEPCS_LFSR_W 11
`define FEPCS_TAP_HI 10
`define FEPCS_TAP_LO 8
`define FEPCS_SEED_LOW 7'h55
`define FEPCS_CODE_I 5'h1F
`define FEPCS_CODE_J 5'h18
`define FEPCS_CODE_K 5'h11
`define FEPCS_CODE_T 5'h0D
`define FEPCS_CODE_R 5'h07
`define FEPCS_LOCK_GROUPS 12
`define FEPCS_LOCK_BITS (`FEPCS_LOCK_GROUPS * `FEPCS_SYM_W)
`define FEPCS_IDLE_BITS 58
`define FEPCS_CLK_MHZ 50
`define FEPCS_HOLD_NS 722000
`define FEPCS_HOLD_CYC ((`FEPCS_HOLD_NS * `FEPCS_CLK_MHZ) / 1000)

`endif

// File: hw/fepcs_pkg.sv
// Types for the 100 Mb/s line coding block
package fepcs_pkg;
	typedef enum logic [2:0] {
		FEPCS_TX_IDLE = 3'h0,
		FEPCS_TX_J = 3'h1,
		FEPCS_TX_K = 3'h3,
		FEPCS_TX_DATA = 3'h2,
		FEPCS_TX_T = 3'h6,
		FEPCS_TX_R = 3'h7
	} fepcs_tx_st_t;
	typedef enum logic {
		FEPCS_RX_HUNT = 1'b0,
		FEPCS_RX_LOCK = 1'b1
	} fepcs_rx_st_t;
endpackage

// File: testbench/fepcs_mac_model.sv
// MAC side model presenting transmit nibbles
`timescale 1ns/1ps
`default_nettype none
module fepcs_mac_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [4:0] nibCount,
	input wire logic [63:0] frame,
	input wire logic txNibbleTake,
	output logic txEn = 1'b0,
	output logic [3:0] txd = 4'h0
);
	logic [4:0] idx = 5'h0;
	always @(posedge mclk)
	begin
		if (!rstn)
		begin
			txEn <= 1'b0;
			idx <= 5'h0;
		end
		else if (start)
		begin
			txEn <= 1'b1;
			txd <= frame[3:0];
			idx <= 5'h1;
		end
		else if (txNibbleTake && txEn)
		begin
			if (idx == nibCount)
			begin
				txEn <= 1'b0;
				txd <= ~txd;
			end
			else
				txd <= frame[idx*4 +: 4];
			idx <= idx + 5'h1;
		end
	end
endmodule
`default_nettype wire

// File: testbench/fepcs_line_coding_test.sv
// Self-checking bench for the 100 Mb/s line coding block
`timescale 1ns/1ps
`default_nettype none
`include "fepcs_consts.svh"
module fepcs_line_coding_test;
	localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic mclk = 1'b0, rstn = 1'b0, start = 1'b0, encBypass = 1'b0, scrBypass = 1'b1;
	logic loop = 1'b0, energy = 1'b0, linkPulse = 1'b0, rxPos = 1'b0, rxNeg = 1'b0;
	logic [4:0] straps = 5'h00, nibCount = 5'h00, txSymIn = 5'h00;
	logic [63:0] frame = 64'h0;
	wire logic txEn, txNibbleTake, txPos, txNeg, sigDetect, rxLocked, rxSymValid;
	wire logic [3:0] txd;
	wire logic [4:0] rxSym;
	integer seed = 32'h62749a77;
	int failures = 0, checksDone = 0, bitCnt = 0;
	logic [4:0] expQ[$], rxQ[$];
	logic [1:0] prevPair = 2'h0;
	logic [9:0] sh = 10'h000;
	logic inFrame = 1'b0;

	fepcs_line_coding #(.HOLD_CYCLES(300)) DUT (.mclk(mclk), .rstn(rstn),
		.phy_address_straps(straps), .txEn(txEn), .txd(txd), .txSymIn(txSymIn),
		.encBypass(encBypass), .scrBypass(scrBypass), .txNibbleTake(txNibbleTake),
		.txPos(txPos), .txNeg(txNeg), .rxPosPin(rxPos), .rxNegPin(rxNeg),
		.energyPin(energy), .linkPulsePin(linkPulse), .sigDetect(sigDetect),
		.rxLocked(rxLocked), .rxSym(rxSym), .rxSymValid(rxSymValid));
	fepcs_mac_model MAC (.mclk(mclk), .rstn(rstn), .start(start), .nibCount(nibCount),
		.frame(frame), .txNibbleTake(txNibbleTake), .txEn(txEn), .txd(txd));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("failures %0d checks %0d", failures, checksDone);
		if (failures == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always #10 mclk = ~mclk;

	always @(posedge mclk)
	begin
		rxPos <= loop & txPos;
		rxNeg <= loop & txNeg;
	end

	// Line decoder: a change of the driven pair marks a one
	always @(negedge mclk)
	begin
		if (rstn)
		begin
			check({txPos, txNeg} == 2'b11, 1'b0);
			sh = {sh[8:0], {txPos, txNeg} != prevPair};
			prevPair = {txPos, txNeg};
			if (!inFrame && scrBypass && sh == {`FEPCS_CODE_J, `FEPCS_CODE_K})
			begin
				inFrame = 1'b1;
				bitCnt = 0;
			end
			else if (inFrame)
			begin
				bitCnt++;
				if (bitCnt == 5 && expQ.size() > 0)
				begin
					bitCnt = 0;
					check(sh[4:0], expQ.pop_front());
					inFrame = (expQ.size() > 0);
				end
			end
			if (rxSymValid && rxQ.size() > 0)
				check(rxSym, rxQ.pop_front());
		end
	end

	initial
	begin
		int i;
		int b;
		logic [39:0] v;
		repeat (5) @(posedge mclk);
		check({txNibbleTake, txPos, txNeg, sigDetect, rxLocked, rxSymValid}, 6'h00);
		rstn <= 1'b1;
		straps <= 5'($random(seed));
		repeat (20) @(posedge mclk);
		for (b = 0; b < 2; b++)
		begin
			encBypass <= b[0];
			txSymIn <= 5'($random(seed));
			frame <= {$random(seed), $random(seed)};
			nibCount <= 5'h0C;
			start <= 1'b1;
			@(posedge mclk);
			start <= 1'b0;
			for (i = 2; i < 12; i++)
				expQ.push_back(b ? txSymIn : ENC[frame[i*4 +: 4]]);
			expQ.push_back(`FEPCS_CODE_T);
			expQ.push_back(`FEPCS_CODE_R);
			repeat (3) expQ.push_back(`FEPCS_CODE_I);
			for (i = 0; i < 200 && expQ.size() > 0; i++)
				@(posedge mclk);
			check(16'(expQ.size()), 16'h0000);
		end
		scrBypass <= 1'b0;
		loop <= 1'b1;
		for (i = 0; i < 400 && rxLocked !== 1'b1; i++)
			@(posedge mclk);
		check(rxLocked, 1'b1);
		repeat (8) rxQ.push_back(`FEPCS_CODE_I);
		repeat (1000) @(posedge mclk);
		check(16'(rxQ.size()), 16'h0000);
		check(rxLocked, 1'b1);
		loop <= 1'b0;
		repeat (200) @(posedge mclk);
		check(rxLocked, 1'b1);
		repeat (200) @(posedge mclk);
		check(rxLocked, 1'b0);
		for (i = 0; i < 40; i++)
		begin
			@(posedge mclk);
			energy <= 1'($random(seed));
			linkPulse <= 1'($random(seed));
			@(negedge mclk);
			v[i] = energy & ~linkPulse;
			if (i >= 3)
				check(sigDetect, v[i-3]);
		end
		results();
	end

	initial
	begin
		#200000;
		failures++;
		results();
	end
endmodule
`default_nettype wire
